// ### rtl/lcc_pkg.sv
// Constants for one logic cluster of sixteen cell registers and its control-signal selection.
// Assumes a single 50 MHz clock and the plain register port of lcc_cluster.
//
// Summary of operation
// - cluster offers two clocks, two gates, two async clears, sync clear, sync load.
// - at most eight control signals in use at once, one per slot.
// - synchronous load is blocked while register packing is selected.
// - at most four control slots may select non-global local routing.
// - sync clear and sync load act on every ticked register together.
// - each cluster clock is always gated by its own paired gate.
// - dual-edge use drives clock two from the falling edge of clock one.
// - a deasserted gate stops its clock, so its registers hold.
// - each slot selects one of six row clocks, a local routing line, or off (no source).
// - each register may be cleared by async clear line one or two.
// - no preset line; a clear loads the cell's polarity value instead.
// - a register is either preset-emulating or plain clearing, never both.
// - device-wide clear, when built in, clears every register above all else.
// - a register may take the previous cell's output as a shift cascade.
// - every register has data, clock, gate and clear from cluster signals.
package lcc_pkg;

  localparam int NCELL = 16;
  localparam int NSLOT = 8;
  localparam int SELW  = 3;
  localparam int NROW  = 6;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_CLK    = 8'h08;
  localparam logic [7:0] OFS_CLR    = 8'h0C;
  localparam logic [7:0] OFS_PRESET = 8'h10;
  localparam logic [7:0] OFS_CHAIN  = 8'h14;
  localparam logic [7:0] OFS_Q      = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;

  // ------------------------------------------------------------
  // slots, source codes, fields, reset values
  // ------------------------------------------------------------
  localparam int SL_CLK1  = 0;
  localparam int SL_CLK2  = 1;
  localparam int SL_GATE1 = 2;
  localparam int SL_GATE2 = 3;
  localparam int SL_ACLR1 = 4;
  localparam int SL_ACLR2 = 5;
  localparam int SL_SCLR  = 6;
  localparam int SL_SLOAD = 7;

  localparam logic [2:0]  SRC_LOCAL = 3'h6;
  localparam logic [2:0]  SRC_OFF   = 3'h7;
  localparam logic [3:0]  NG_MAX    = 4'h4;
  localparam int          MODE_BOTH = 0;
  localparam int          MODE_PACK = 1;
  localparam int          CLR_LINE  = 16;
  localparam int          STAT_REJ  = 0;
  localparam int          STAT_NG   = 4;
  localparam logic [23:0] SLOT_RST  = 24'hFFFFFF;
  localparam logic [15:0] CELL_RST  = 16'h0000;

endpackage

// ### rtl/lcc_cluster.sv
// Logic cluster: control-signal selection and sixteen cell registers with cascade.
// Assumes row clocks and the device clear arrive asynchronously; local lines and
// cell data come from logic on clk_i.
`timescale 1ns/1ns
module lcc_cluster
  import lcc_pkg::*;
#(
  parameter bit DEV_CLEAR_EN = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output wire logic [31:0] rdata_o,
  input  wire logic [5:0]  row_clock_i,
  input  wire logic [7:0]  local_ctrl_i,
  input  wire logic        device_wide_clear_n_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] load_data_i,
  input  wire logic        cascade_in_i,
  output wire logic [15:0] cell_q_o,
  output wire logic        cascade_out_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [23:0] slot_sel_q;
  logic        mode_both_q;
  logic        mode_pack_q;
  logic [15:0] clk_sel_q;
  logic [15:0] clr_en_q;
  logic [15:0] clr_line_q;
  logic [15:0] preset_q;
  logic [15:0] chain_q;
  logic [15:0] cell_q_q;
  logic [15:0] cell_d;
  logic        rej_q;
  logic [31:0] rdata_q;
  logic [5:0]  row_meta_q;
  logic [5:0]  row_sync_q;
  logic [5:0]  row_prev_q;
  logic [7:0]  loc_prev_q;
  logic        dclr_meta_q;
  logic        dclr_sync_q;

  function automatic logic [3:0] ng_count(input logic [23:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NSLOT; i++) begin
      if (v[i*SELW +: SELW] == SRC_LOCAL) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      row_meta_q  <= 6'h00;
      row_sync_q  <= 6'h00;
      row_prev_q  <= 6'h00;
      loc_prev_q  <= 8'h00;
      dclr_meta_q <= 1'b1;
      dclr_sync_q <= 1'b1;
    end else begin
      row_meta_q  <= row_clock_i;
      row_sync_q  <= row_meta_q;
      row_prev_q  <= row_sync_q;
      loc_prev_q  <= local_ctrl_i;
      dclr_meta_q <= device_wide_clear_n_i;
      dclr_sync_q <= dclr_meta_q;
    end
  end

  // ------------------------------------------------------------
  // control slot selection
  // ------------------------------------------------------------
  wire [7:0] row_now = {2'b00, row_sync_q};
  wire [7:0] row_old = {2'b00, row_prev_q};
  wire [7:0] slot_lvl;
  wire [7:0] slot_rise;
  wire [7:0] slot_fall;
  wire [7:0] slot_off;

  // one slot per control signal keeps the count at eight
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    wire [2:0] sel    = slot_sel_q[s*SELW +: SELW];
    wire       is_row = sel < SRC_LOCAL;
    wire       is_loc = sel == SRC_LOCAL;
    wire       old    = is_row ? row_old[sel]
                               : (is_loc & loc_prev_q[s]);
    assign slot_lvl[s]  = is_row ? row_now[sel]
                                 : (is_loc & local_ctrl_i[s]);
    assign slot_rise[s] = slot_lvl[s] & ~old;
    assign slot_fall[s] = ~slot_lvl[s] & old;
    assign slot_off[s]  = sel == SRC_OFF;
  end

  // ------------------------------------------------------------
  // cluster-wide control lines
  // ------------------------------------------------------------
  // an unused gate slot leaves its clock running
  wire gate1 = slot_off[SL_GATE1] | slot_lvl[SL_GATE1];
  wire gate2 = slot_off[SL_GATE2] | slot_lvl[SL_GATE2];

  wire clk2_edge = mode_both_q ? slot_fall[SL_CLK1]
                               : slot_rise[SL_CLK2];

  wire tick1 = slot_rise[SL_CLK1] & gate1;
  wire tick2 = clk2_edge & gate2;

  wire aclr1 = slot_lvl[SL_ACLR1];
  wire aclr2 = slot_lvl[SL_ACLR2];
  wire sclr  = slot_lvl[SL_SCLR];
  wire sload = slot_lvl[SL_SLOAD] & ~mode_pack_q;

  wire devclr = DEV_CLEAR_EN & ~dclr_sync_q;

  // ------------------------------------------------------------
  // cell registers
  // ------------------------------------------------------------
  wire [15:0] chain_in = {cell_q_q[14:0], cascade_in_i};
  wire [15:0] tick_vec;
  wire [15:0] aclr_vec;
  wire [15:0] din_vec;

  for (genvar c = 0; c < NCELL; c++) begin : g_cell
    assign tick_vec[c] = clk_sel_q[c] ? tick2 : tick1;
    assign aclr_vec[c] = clr_en_q[c]
                       & (clr_line_q[c] ? aclr2 : aclr1);
    assign din_vec[c]  = chain_q[c] ? chain_in[c]
                                    : data_i[c];
    // any clear lands on the cell's polarity value, so preset and clear never coexist
    assign cell_d[c] = (devclr | aclr_vec[c]) ? preset_q[c]
                     : !tick_vec[c]           ? cell_q_q[c]
                     : sclr                   ? preset_q[c]
                     : sload                  ? load_data_i[c]
                     : din_vec[c];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cell_q_q <= CELL_RST;
    end else begin
      cell_q_q <= cell_d;
    end
  end

  assign cell_q_o      = cell_q_q;
  assign cascade_out_o = cell_q_q[NCELL-1];

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire       wr_slot = we_i & (addr_i == OFS_SLOT);
  wire [3:0] wr_ng   = ng_count(wdata_i[23:0]);
  wire       wr_ok   = wr_ng <= NG_MAX;
  wire [3:0] ng_cur  = ng_count(slot_sel_q);

  wire [31:0] rd_mux =
      (addr_i == OFS_SLOT)   ? {8'h00, slot_sel_q}
    : (addr_i == OFS_MODE)   ? {30'h0, mode_pack_q, mode_both_q}
    : (addr_i == OFS_CLK)    ? {16'h0000, clk_sel_q}
    : (addr_i == OFS_CLR)    ? {clr_line_q, clr_en_q}
    : (addr_i == OFS_PRESET) ? {16'h0000, preset_q}
    : (addr_i == OFS_CHAIN)  ? {16'h0000, chain_q}
    : (addr_i == OFS_Q)      ? {16'h0000, cell_q_q}
    : (addr_i == OFS_STAT)   ? {24'h000000, ng_cur, 3'h0, rej_q}
    : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= re_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_sel_q  <= SLOT_RST;
      mode_both_q <= 1'b0;
      mode_pack_q <= 1'b0;
      clk_sel_q   <= CELL_RST;
      clr_en_q    <= CELL_RST;
      clr_line_q  <= CELL_RST;
      preset_q    <= CELL_RST;
      chain_q     <= CELL_RST;
      rej_q       <= 1'b0;
    end else if (we_i) begin
      unique case (addr_i)
        OFS_SLOT: begin
          rej_q <= ~wr_ok;
          if (wr_ok) begin
            slot_sel_q <= wdata_i[23:0];
          end
        end
        OFS_MODE: begin
          mode_both_q <= wdata_i[MODE_BOTH];
          mode_pack_q <= wdata_i[MODE_PACK];
        end
        OFS_CLK: begin
          clk_sel_q <= wdata_i[15:0];
        end
        OFS_CLR: begin
          clr_en_q   <= wdata_i[15:0];
          clr_line_q <= wdata_i[CLR_LINE +: 16];
        end
        OFS_PRESET: begin
          preset_q <= wdata_i[15:0];
        end
        OFS_CHAIN: begin
          chain_q <= wdata_i[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_nonglobal_limit: assert property (
    ng_cur <= NG_MAX)
    else $error("more than four local control slots");

  a_reject_keeps_sel: assert property (
    wr_slot && !wr_ok |=> rej_q && $stable(slot_sel_q))
    else $error("over-limit slot write was taken");

  a_pair_gate_one: assert property (
    !gate1 |-> !tick1)
    else $error("clock one ticked with its gate low");

  a_both_edges: assert property (
    mode_both_q && slot_fall[SL_CLK1] && gate2 |-> tick2)
    else $error("falling edge did not drive clock two");

  a_gate_hold: assert property (
    !devclr |=> ((cell_q_q ^ $past(cell_q_q))
               & $past(~tick_vec & ~aclr_vec)) == 16'h0000)
    else $error("register moved without a gated tick");

  a_aclr_first: assert property (
    !devclr && (aclr_vec != 16'h0000) |=>
      ((cell_q_q ^ $past(preset_q)) & $past(aclr_vec)) == 16'h0000)
    else $error("async clear did not win");

  a_sclr_all: assert property (
    sclr && !devclr |=>
      ((cell_q_q ^ $past(preset_q)) & $past(tick_vec)) == 16'h0000)
    else $error("sync clear missed a ticked register");

  a_sload_packing: assert property (
    mode_pack_q && !sclr && !devclr |=>
      ((cell_q_q ^ $past(din_vec)) & $past(tick_vec & ~aclr_vec)) == 16'h0000)
    else $error("sync load acted under packing");

  a_sload_value: assert property (
    sload && !sclr && !devclr |=>
      ((cell_q_q ^ $past(load_data_i)) & $past(tick_vec & ~aclr_vec)) == 16'h0000)
    else $error("sync load value wrong");

  a_devclr_all: assert property (
    devclr |=> cell_q_q == $past(preset_q))
    else $error("device clear did not clear all");

  a_chain_shift: assert property (
    !devclr && !sclr && !sload |=>
      ((cell_q_q ^ $past(chain_in)) & $past(chain_q & tick_vec & ~aclr_vec)) == 16'h0000)
    else $error("cascade did not shift");

  a_pair_gate_two: assert property (
    !gate2 |-> !tick2)
    else $error("clock two ticked with its gate low");

  a_pair_one_only: assert property (
    !devclr |=>
      ((cell_q_q ^ $past(cell_q_q)) & $past(~clk_sel_q & ~aclr_vec)
        & {NCELL{~$past(tick1)}}) == 16'h0000)
    else $error("pair one cell moved without clock one");

  a_pair_two_only: assert property (
    !devclr |=>
      ((cell_q_q ^ $past(cell_q_q)) & $past(clk_sel_q & ~aclr_vec)
        & {NCELL{~$past(tick2)}}) == 16'h0000)
    else $error("pair two cell moved without clock two");

  a_sload_blocked: assert property (
    mode_pack_q |-> !sload)
    else $error("sync load live under packing");

  a_gates_off_hold: assert property (
    !gate1 && !gate2 && !devclr && (aclr_vec == 16'h0000) |=> $stable(cell_q_q))
    else $error("registers moved with both gates low");

  a_aclr_line_two: assert property (
    !devclr && aclr2 && ((clr_en_q & clr_line_q) != 16'h0000) |=>
      ((cell_q_q ^ $past(preset_q)) & $past(clr_en_q & clr_line_q)) == 16'h0000)
    else $error("async clear two missed a cell");

  a_devclr_override: assert property (
    devclr |-> cell_d == preset_q)
    else $error("device clear did not override");

  a_devclr_latency: assert property (
    DEV_CLEAR_EN && !dclr_meta_q |=> devclr)
    else $error("device clear not applied after sync");

  a_slot_accept: assert property (
    wr_slot && wr_ok |=> !rej_q && (slot_sel_q == $past(wdata_i[23:0])))
    else $error("legal slot write was not taken");

  a_cascade_out: assert property (
    cascade_out_o == cell_q_q[NCELL-1])
    else $error("cascade output not last cell");

  c_row_tick:    cover property ((slot_sel_q[SELW-1:0] < SRC_LOCAL) && tick1);
  c_sclr_tick:   cover property (tick1 && sclr);
  c_dual_edge:   cover property (mode_both_q && tick2 && (clk_sel_q != 16'h0000));
  c_slot_reject: cover property (wr_slot && !wr_ok);
  c_chain_run:   cover property ((chain_q != 16'h0000) && (tick_vec != 16'h0000));

endmodule  // lcc_cluster

// ### testbench/lcc_user_model.sv
// Model of the user logic that feeds the cluster's local and row control lines.
// Assumes the bench asks for levels and one-cycle pulses, changed on clk_i.
`timescale 1ns/1ns
module lcc_user_model
  import lcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] pulse_i,
  input  wire logic       row_step_i,
  output wire logic [7:0] local_ctrl_o,
  output wire logic [5:0] row_clock_o
);
  logic [7:0] local_q;
  logic [5:0] row_q;
  assign local_ctrl_o = local_q;
  assign row_clock_o  = row_q;
  // row clocks stand still until a step is asked for
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      local_q <= 8'h00;
      row_q   <= 6'h00;
    end else begin
      local_q <= level_i | pulse_i;
      if (row_step_i) begin
        row_q <= ~row_q;
      end
    end
  end
endmodule // lcc_user_model

// ### testbench/testbench.sv
// Self-checking bench for the logic cluster, with the user-logic model.
// Assumes lcc_pkg offsets and the register-port timing of lcc_cluster.
`timescale 1ns/1ns
module testbench;
  import lcc_pkg::*;
  logic        clk, rstn, we, re, cin, dclr_n, step, cout;
  logic [7:0]  addr, lvl, pls, lctl;
  logic [31:0] wdata, rdata, v;
  logic [15:0] din, ldin, q;
  logic [5:0]  rowc;
  int          error_cnt, checks;
  lcc_user_model lcc_user_model_i (.clk_i(clk), .rstn_i(rstn), .level_i(lvl), .pulse_i(pls),
    .row_step_i(step), .local_ctrl_o(lctl), .row_clock_o(rowc));
  lcc_cluster #(.DEV_CLEAR_EN(1'b1)) lcc_cluster_i (.clk_i(clk), .rstn_i(rstn), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .row_clock_i(rowc),
    .local_ctrl_i(lctl), .device_wide_clear_n_i(dclr_n), .data_i(din), .load_data_i(ldin),
    .cascade_in_i(cin), .cell_q_o(q), .cascade_out_o(cout));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a; re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask
  task automatic tick(input logic [7:0] m);
    @(posedge clk);
    pls <= m;
    @(posedge clk);
    pls <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic setl(input logic [7:0] m);
    @(posedge clk);
    lvl <= m;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0; we = 1'b0; re = 1'b0; cin = 1'b1; dclr_n = 1'b1; step = 1'b0;
    addr = 8'h00; lvl = 8'h00; pls = 8'h00; wdata = 32'h0; din = 16'hA5C3; ldin = 16'h5A5A;
    error_cnt = 0; checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rc("slot_rst", OFS_SLOT, 32'h00FFFFFF);
    rc("q_rst", OFS_Q, 32'h0);
    rc("unmapped", 8'h20, 32'h0);
    wr(OFS_SLOT, 32'h00FBEFBE);
    rc("stat_four", OFS_STAT, 32'h40);
    wr(OFS_SLOT, 32'h00DBEFBE);
    rc("slot_kept", OFS_SLOT, 32'h00FBEFBE);
    chk("cascade_out", 32'h0, {31'h0, cout});
    rd(OFS_STAT);
    chk("stat_rej", 32'h1, {31'h0, v[0]});
    setl(8'h04);
    tick(8'h01);
    chk("tick_load", 32'hA5C3, {16'h0, q});
    setl(8'h00);
    din <= 16'h1234;
    tick(8'h01);
    chk("gate_hold", 32'hA5C3, {16'h0, q});
    setl(8'h44);
    tick(8'h01);
    chk("sync_clear", 32'h0, {16'h0, q});
    setl(8'h04);
    wr(OFS_CHAIN, 32'hFFFF);
    tick(8'h01);
    tick(8'h01);
    chk("cascade", 32'h3, {16'h0, q});
    wr(OFS_CHAIN, 32'h0);
    wr(OFS_CLK, 32'hFF00);
    din <= 16'hFFFF;
    tick(8'h01);
    chk("pair_two", 32'h00FF, {16'h0, q});
    wr(OFS_CLK, 32'h0);
    wr(OFS_SLOT, 32'h00DFFFFE);
    wr(OFS_MODE, 32'h2);
    setl(8'h80);
    tick(8'h01);
    chk("pack_noload", 32'hFFFF, {16'h0, q});
    wr(OFS_MODE, 32'h0);
    tick(8'h01);
    chk("sync_load", 32'h5A5A, {16'h0, q});
    @(posedge clk);
    dclr_n <= 1'b0;
    repeat (4) @(posedge clk);
    dclr_n <= 1'b1;
    #1 chk("dev_clear", 32'h0, {16'h0, q});
    wr(OFS_SLOT, 32'h00FBEFBE);
    setl(8'h04);
    tick(8'h01);
    wr(OFS_PRESET, 32'h000F);
    wr(OFS_CLR, 32'hFF00FFFF);
    setl(8'h14);
    repeat (3) @(posedge clk);
    #1 chk("aclr_preset", 32'hFF0F, {16'h0, q});
    setl(8'h04);
    wr(OFS_SLOT, 32'h00FFFFFA);
    din <= 16'h1357;
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("row_clock", 32'h1357, {16'h0, q});
    // dual edge: clock two follows the falling edge of clock one's local line
    wr(OFS_SLOT, 32'h00FBEFBE);
    wr(OFS_MODE, 32'h1);
    wr(OFS_CLK, 32'hFFFF);
    din <= 16'h2468;
    tick(8'h01);
    chk("dual_edge", 32'h2468, {16'h0, q});
    chk("cascade_top", 32'h0, {31'h0, cout});
    tally_and_finish;
  end
endmodule // testbench
